// ===== core/vpas_top.sv
// Voltage-mode PWM amplitude scaler with register port and open-load flags.
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// [RULE1] Feed-forward amplitude uses only step interval.
// [RULE2] Total equals offset plus gradient times 256/interval.
// [RULE3] Eight-bit amplitude; sine peaks at 248/256.
// [RULE4] Voltage mode only below threshold velocity.
// [RULE5] Zero threshold keeps voltage mode always.
// [RULE6] Hold regulator amplitude while in current mode.
// [RULE7] Host settles at standstill 128 chopper periods.
// [RULE8] Host clears errors, restarts from zero velocity.
// [RULE9] Open-load flag when target missed recent fullsteps.
// [RULE10] Summed amplitude readable, saturates at 255.
// [RULE11] Tuned offset and gradient are readable.
// [RULE12] Threshold is 20-bit interval; below disables.
// [RULE13] Offset and gradient 8-bit, seed tuning.
// [RULE14] Clamp total at 255, never wrap.
module vpas_top
    import vpas_pkg::*;
(
    input wire logic i_clk,              // Core clock, 100 MHz.
    input wire logic i_reset,            // Synchronous reset, active high.
    input wire logic [3:0] i_addr,       // Register index.
    input wire logic [31:0] i_wdata,     // Register write data.
    input wire logic i_wr,               // Write strobe.
    input wire logic i_rd,               // Read strobe.
    input wire logic i_step,             // Microstep pulse, same clock.
    input wire logic i_fullstep,         // Fullstep pulse, same clock.
    input wire logic i_pwm_period,       // Chopper period pulse.
    input wire logic i_coil_a_reached,   // Coil A at target, from pin.
    input wire logic i_coil_b_reached,   // Coil B at target, from pin.
    input wire logic i_current_low,      // Coil current below target, pin.
    output logic [31:0] o_rdata,         // Read data, cycle after strobe.
    output logic o_irq,                  // Level interrupt.
    output logic [7:0] o_amplitude,      // Sine peak amplitude to chopper.
    output logic o_voltage_mode,         // Voltage-mode chopper selected.
    output logic o_open_coil_a_flag,     // Open load on coil A.
    output logic o_open_coil_b_flag      // Open load on coil B.
);
    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic en;
        logic autoscale;
        logic run_auto_q;
        logic [19:0] thresh;
        logic [7:0] amplitude_offset;
        logic [7:0] amplitude_gradient;
        vpas_mode_e mode;
        logic [7:0] reg_amp;
        logic [7:0] tuned_offset;
        logic [7:0] tuned_gradient;
        logic [7:0] amplitude_total;
        logic [7:0] peak;
        logic [1:0][2:0] fs;
        logic [1:0] open;
        logic [3:0] status;
        logic [3:0] mask;
        logic [31:0] rdata;
        logic div_wait;
        logic div_go;
        logic [15:0] div_num;
        logic [19:0] div_den;
    } vpas_top_s;

    vpas_top_s s;
    vpas_top_s next_s;
    vpas_if u_bus();
    logic [3:0] clr;
    logic [3:0] ev;
    logic [16:0] ff_sum;
    logic [16:0] prod;
    logic run_auto;
    vpas_mode_e next_mode;

    // =========================================================
    // Helpers
    vpas_step_meas u_meas (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_step(i_step),
        .bus(u_bus)
    );

    vpas_div u_div (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .bus(u_bus)
    );

    assign u_bus.div_start = s.div_go;
    assign u_bus.div_num = s.div_num;
    assign u_bus.div_den = s.div_den;

    // =========================================================
    // Next state
    always_comb begin
        next_s = s;
        clr = '0;
        ev = '0;
        ff_sum = '0;
        prod = '0;
        next_s.sync1 = {i_current_low, i_coil_b_reached, i_coil_a_reached};
        next_s.sync2 = s.sync1;
        next_s.rdata = '0;
        next_s.div_go = 1'b0;
        run_auto = s.en & s.autoscale;

        if (i_wr) begin
            case (i_addr)
                ADDR_CTRL: begin
                    next_s.en = i_wdata[CTRL_EN];
                    next_s.autoscale = i_wdata[CTRL_AUTO];
                end
                ADDR_THRESH: begin
                    next_s.thresh = i_wdata[INT_W-1:0]; // [RULE12]
                end
                ADDR_FF: begin
                    next_s.amplitude_offset = i_wdata[AMP_W-1:0]; // [RULE13]
                    next_s.amplitude_gradient = i_wdata[2*AMP_W-1:AMP_W];
                end
                ADDR_STATUS: begin
                    clr = i_wdata[ST_W-1:0];
                end
                ADDR_MASK: begin
                    next_s.mask = i_wdata[ST_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Chopper selection by step interval.
        if (!s.en) begin
            next_mode = MODE_OFF;
        end else if (s.thresh == '0) begin
            next_mode = MODE_VOLT; // [RULE5]
        end else if (u_bus.interval < s.thresh) begin
            next_mode = MODE_CURR; // [RULE4]
        end else begin
            next_mode = MODE_VOLT; // [RULE12]
        end
        next_s.mode = next_mode;
        ev[ST_MODE] = (next_mode != s.mode);

        // Regulator. It is frozen outside voltage mode so that it resumes
        // from the last known amplitude after a fast stretch.
        next_s.run_auto_q = run_auto;
        if (run_auto && !s.run_auto_q) begin
            next_s.reg_amp = s.amplitude_offset; // [RULE13]
            next_s.tuned_offset = s.amplitude_offset;
            next_s.tuned_gradient = s.amplitude_gradient;
        end else if (run_auto && s.mode == MODE_VOLT && i_pwm_period) begin
            if (s.sync2[SY_LOW]) begin // [RULE6]
                next_s.reg_amp = vpas_sat8({9'h000, s.reg_amp} + 17'h0_0001);
            end else if (s.reg_amp != AMP_ZERO) begin
                next_s.reg_amp = s.reg_amp - 8'h01;
            end
            if (u_bus.interval == INTERVAL_MAX) begin
                next_s.tuned_offset = s.reg_amp; // [RULE11]
            end
        end

        // Feed-forward term, recomputed continuously.
        if (!s.div_wait) begin
            next_s.div_go = 1'b1;
            next_s.div_wait = 1'b1;
            next_s.div_num = {s.amplitude_gradient, AMP_ZERO}; // [RULE2]
            next_s.div_den = u_bus.interval; // [RULE1]
        end else if (u_bus.div_done) begin
            next_s.div_wait = 1'b0;
        end

        if (s.mode == MODE_OFF) begin
            next_s.amplitude_total = AMP_ZERO;
        end else if (s.mode == MODE_VOLT && run_auto) begin
            next_s.amplitude_total = s.reg_amp;
        end else if (s.mode == MODE_VOLT && u_bus.div_done) begin
            ff_sum = {9'h000, s.amplitude_offset} + {1'b0, u_bus.div_quot};
            next_s.amplitude_total = vpas_sat8(ff_sum); // [RULE14]
        end
        ev[ST_SAT] = (next_s.amplitude_total == AMP_MAX) &&
                     (s.amplitude_total != AMP_MAX); // [RULE10]
        prod = {9'h000, next_s.amplitude_total} * {8'h00, SINE_PEAK};
        next_s.peak = prod[15:8]; // [RULE3]

        // Open-load watch per coil.
        for (int c = 0; c < COILS; c++) begin
            if (s.mode != MODE_VOLT || s.sync2[c]) begin
                next_s.fs[c] = '0;
            end else if (i_fullstep && s.fs[c] != OPEN_FULLSTEPS) begin
                next_s.fs[c] = s.fs[c] + 3'h1;
            end
            next_s.open[c] = (s.mode == MODE_VOLT) &&
                             (next_s.fs[c] == OPEN_FULLSTEPS); // [RULE9]
            ev[ST_OPEN_A + c] = next_s.open[c];
        end

        // A new event beats a clear in the same cycle.
        next_s.status = (s.status & ~clr) | ev;

        if (i_rd) begin
            case (i_addr)
                ADDR_CTRL: begin
                    next_s.rdata = {30'h0000_0000, s.autoscale, s.en};
                end
                ADDR_THRESH: begin
                    next_s.rdata = {12'h000, s.thresh};
                end
                ADDR_FF: begin
                    next_s.rdata = {16'h0000, s.amplitude_gradient,
                                    s.amplitude_offset};
                end
                ADDR_INTERVAL: begin
                    next_s.rdata = {12'h000, u_bus.interval};
                end
                ADDR_AMP: begin
                    next_s.rdata = {s.tuned_gradient, s.tuned_offset,
                                    s.reg_amp, s.amplitude_total}; // [RULE10]
                end
                ADDR_STATUS: begin
                    next_s.rdata = {28'h000_0000, s.status};
                end
                ADDR_MASK: begin
                    next_s.rdata = {28'h000_0000, s.mask};
                end
                default: begin
                    next_s.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s <= '0;
            s.mode <= MODE_OFF;
            s.status <= ST_RESET;
            s.mask <= MASK_RESET;
        end else begin
            s <= next_s;
        end
    end

    // =========================================================
    // Outputs
    assign o_rdata = s.rdata;
    assign o_irq = |(s.status & s.mask);
    assign o_amplitude = s.peak;
    assign o_voltage_mode = (s.mode == MODE_VOLT);
    assign o_open_coil_a_flag = s.open[0];
    assign o_open_coil_b_flag = s.open[1];

    // =========================================================
    // Checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    mode_thr_a: assert property ( // [RULE4]
        (s.en && s.thresh != '0 && u_bus.interval < s.thresh)
        |=> s.mode == MODE_CURR)
        else $error("fast motion did not leave voltage mode");

    zero_thr_a: assert property ( // [RULE5]
        (s.en && s.thresh == '0) |=> s.mode == MODE_VOLT)
        else $error("zero threshold left voltage mode");

    hold_amp_a: assert property ( // [RULE6]
        (s.mode == MODE_CURR && s.run_auto_q && s.en && s.autoscale)
        |=> s.reg_amp == $past(s.reg_amp))
        else $error("regulator amplitude moved in current mode");

    clamp_total_a: assert property ( // [RULE14]
        (u_bus.div_done && s.mode == MODE_VOLT && !s.autoscale &&
         ({9'h000, s.amplitude_offset} + {1'b0, u_bus.div_quot})
         > {9'h000, AMP_MAX})
        |=> s.amplitude_total == AMP_MAX)
        else $error("total amplitude wrapped instead of clamping");

    ff_sum_a: assert property ( // [RULE2]
        (u_bus.div_done && s.mode == MODE_VOLT && !s.autoscale &&
         s.en && ({9'h000, s.amplitude_offset} + {1'b0, u_bus.div_quot})
         <= {9'h000, AMP_MAX})
        |=> s.amplitude_total ==
            $past(s.amplitude_offset) + $past(u_bus.div_quot[7:0]))
        else $error("feed-forward sum is wrong");

    peak_scale_a: assert property ( // [RULE3]
        ({9'h000, s.amplitude_total} * {8'h00, SINE_PEAK}) >> GRAD_SHIFT
        == {9'h000, s.peak})
        else $error("sine peak is not 248/256 of total");

    open_a_a: assert property ( // [RULE9]
        (s.mode == MODE_VOLT && s.fs[0] == OPEN_FULLSTEPS - 3'h1 &&
         i_fullstep && !s.sync2[0])
        |=> o_open_coil_a_flag ##1 s.status[ST_OPEN_A])
        else $error("open load on coil A not flagged");

    set_wins_a: assert property ( // [RULE9]
        (i_wr && i_addr == ADDR_STATUS && i_wdata[ST_OPEN_A] &&
         next_s.open[0]) |=> s.status[ST_OPEN_A])
        else $error("status clear lost a coincident event");

    rd_amp_a: assert property ( // [RULE11]
        (i_rd && i_addr == ADDR_AMP)
        |=> o_rdata == {$past(s.tuned_gradient), $past(s.tuned_offset),
                        $past(s.reg_amp), $past(s.amplitude_total)})
        else $error("amplitude register read back wrong");

    init_tune_a: assert property ( // [RULE13]
        (s.en && s.autoscale && !s.run_auto_q)
        |=> (s.tuned_offset == $past(s.amplitude_offset) &&
             s.tuned_gradient == $past(s.amplitude_gradient)))
        else $error("tuning not seeded from settings");
endmodule
`default_nettype wire

// ===== inc/vpas_pkg.sv
// Constants, types and helpers shared by the voltage PWM amplitude scaler.
package vpas_pkg;
    // =========================================================
    // Widths
    localparam int AMP_W = 8;
    localparam int INT_W = 20;
    localparam int NUM_W = 16;
    localparam int ST_W = 4;
    localparam int ADDR_W = 4;
    localparam int COILS = 2;
    // =========================================================
    // Register indices on the plain register port
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_THRESH = 4'h1;
    localparam logic [3:0] ADDR_FF = 4'h2;
    localparam logic [3:0] ADDR_INTERVAL = 4'h3;
    localparam logic [3:0] ADDR_AMP = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h5;
    localparam logic [3:0] ADDR_MASK = 4'h6;
    // =========================================================
    // Field positions
    localparam int CTRL_EN = 0;
    localparam int CTRL_AUTO = 1;
    localparam int ST_OPEN_A = 0;
    localparam int ST_OPEN_B = 1;
    localparam int ST_SAT = 2;
    localparam int ST_MODE = 3;
    localparam int SY_LOW = 2;
    // =========================================================
    // Values
    localparam logic [19:0] INTERVAL_MAX = 20'hF_FFFF;
    localparam logic [19:0] INTERVAL_ONE = 20'h0_0001;
    localparam logic [7:0] AMP_MAX = 8'hFF;
    localparam logic [7:0] AMP_ZERO = 8'h00;
    localparam logic [8:0] SINE_PEAK = 9'h0F8;
    localparam int GRAD_SHIFT = 8;
    localparam logic [2:0] OPEN_FULLSTEPS = 3'h4;
    localparam logic [4:0] DIV_STEPS = 5'h10;
    localparam logic [3:0] ST_RESET = 4'h0;
    localparam logic [3:0] MASK_RESET = 4'h0;

    typedef enum logic [2:0] {
        MODE_OFF = 3'b001,
        MODE_VOLT = 3'b010,
        MODE_CURR = 3'b100
    } vpas_mode_e;

    // Clamps a wide sum to the 8-bit amplitude range.
    function automatic logic [7:0] vpas_sat8(input logic [16:0] v);
        vpas_sat8 = (v > {9'h000, AMP_MAX}) ? AMP_MAX : v[7:0];
    endfunction
endpackage

// ===== inc/vpas_if.sv
// Interface between the scaler core, its step timer and its divider.
`timescale 1ns/10ps
`default_nettype none
interface vpas_if;
    logic [19:0] interval;
    logic div_start;
    logic [15:0] div_num;
    logic [19:0] div_den;
    logic div_done;
    logic [15:0] div_quot;

    modport meas (output interval);
    modport div (input div_start, input div_num, input div_den,
                 output div_done, output div_quot);
    modport core (input interval, input div_done, input div_quot,
                  output div_start, output div_num, output div_den);
endinterface
`default_nettype wire

// ===== core/vpas_step_meas.sv
// Step interval timer: clock cycles between two microstep pulses.
`timescale 1ns/10ps
`default_nettype none
module vpas_step_meas
    import vpas_pkg::*;
(
    input wire logic i_clk,   // Core clock.
    input wire logic i_reset, // Synchronous reset, active high.
    input wire logic i_step,  // Microstep pulse, 256-step equivalent.
    vpas_if.meas bus          // Measured interval.
);
    typedef struct packed {
        logic [19:0] cnt;
        logic [19:0] interval;
    } vpas_meas_s;

    vpas_meas_s s;
    vpas_meas_s next_s;
    logic [19:0] inc;

    // =========================================================
    // Counter
    always_comb begin
        next_s = s;
        inc = (s.cnt == INTERVAL_MAX) ? INTERVAL_MAX : s.cnt + INTERVAL_ONE;
        next_s.cnt = inc;
        if (i_step) begin
            next_s.interval = inc; // [RULE1]
            next_s.cnt = '0;
        end else if (inc == INTERVAL_MAX) begin
            // A stopped motor reads as the longest interval.
            next_s.interval = INTERVAL_MAX;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s.cnt <= '0;
            s.interval <= INTERVAL_MAX;
        end else begin
            s <= next_s;
        end
    end

    assign bus.interval = s.interval;

    step_count_a: assert property ( // [RULE1]
        @(posedge i_clk) disable iff (i_reset)
        (i_step && s.cnt != INTERVAL_MAX)
        |=> bus.interval == $past(s.cnt) + INTERVAL_ONE)
        else $error("step interval does not match counted cycles");
endmodule
`default_nettype wire

// ===== core/vpas_div.sv
// Restoring divider for the gradient-over-interval term.
`timescale 1ns/10ps
`default_nettype none
module vpas_div
    import vpas_pkg::*;
(
    input wire logic i_clk,   // Core clock.
    input wire logic i_reset, // Synchronous reset, active high.
    vpas_if.div bus           // Division request and result.
);
    typedef struct packed {
        logic busy;
        logic [4:0] cnt;
        logic [15:0] num;
        logic [19:0] den;
        logic [20:0] rem;
        logic [15:0] quot;
        logic done;
    } vpas_div_s;

    vpas_div_s s;
    vpas_div_s next_s;
    logic [20:0] trial;

    // =========================================================
    // One quotient bit per cycle
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        trial = {s.rem[19:0], s.num[NUM_W-1]};
        if (!s.busy) begin
            if (bus.div_start) begin
                next_s.busy = 1'b1;
                next_s.cnt = DIV_STEPS;
                next_s.num = bus.div_num;
                next_s.den = bus.div_den;
                next_s.rem = '0;
                next_s.quot = '0;
            end
        end else begin
            next_s.num = {s.num[NUM_W-2:0], 1'b0};
            // A zero divisor yields all ones, which then clamps.
            if (trial >= {1'b0, s.den}) begin
                next_s.rem = trial - {1'b0, s.den};
                next_s.quot = {s.quot[NUM_W-2:0], 1'b1};
            end else begin
                next_s.rem = trial;
                next_s.quot = {s.quot[NUM_W-2:0], 1'b0};
            end
            next_s.cnt = s.cnt - 5'h01;
            if (s.cnt == 5'h01) begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign bus.div_done = s.done;
    assign bus.div_quot = s.quot;

    div_len_a: assert property ( // [RULE2]
        @(posedge i_clk) disable iff (i_reset)
        (bus.div_start && !s.busy) |-> ##17 bus.div_done)
        else $error("division did not finish in seventeen cycles");
endmodule
`default_nettype wire

// ===== bench/vpas_coil_model.sv
// Behavioural model of the power stage and the two motor coils.
`timescale 1ns/10ps
`default_nettype none
module vpas_coil_model #(
    parameter int PERIOD = 32
) (
    input wire logic i_clk,             // Core clock.
    input wire logic i_reset,           // Synchronous reset, active high.
    input wire logic [7:0] i_amplitude, // Sine peak amplitude applied.
    input wire logic [7:0] i_target,    // Amplitude giving full current.
    input wire logic i_open_a,          // Coil A wire broken.
    input wire logic i_open_b,          // Coil B wire broken.
    output logic o_pwm_period,          // One pulse per chopper period.
    output logic o_coil_a_reached,      // Coil A at target current.
    output logic o_coil_b_reached,      // Coil B at target current.
    output logic o_current_low          // Coil current below target.
);
    int cnt;

    // The shunt is only judged once per period, so feedback lags a period.
    always @(posedge i_clk) begin
        if (i_reset) begin
            cnt <= 0;
            o_pwm_period <= 1'b0;
            o_current_low <= 1'b0;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            o_pwm_period <= (cnt == PERIOD - 1);
            if (cnt == PERIOD - 1) begin
                o_current_low <= (i_amplitude < i_target);
            end
        end
        o_coil_a_reached <= !i_open_a && !o_current_low;
        o_coil_b_reached <= !i_open_b && !o_current_low;
    end
endmodule
`default_nettype wire

// ===== bench/tb_voltage_pwm_amplitude_scaler.sv
// Self-checking bench for the voltage PWM amplitude scaler.
`timescale 1ns/10ps
`default_nettype none
module tb_voltage_pwm_amplitude_scaler
    import vpas_pkg::*;
();
    logic i_clk = 0, i_reset = 1, i_wr = 0, i_rd = 0;
    logic i_step = 0, i_fullstep = 0, open_a = 0, open_b = 0;
    logic [3:0] i_addr = '0;
    logic [31:0] i_wdata = '0, o_rdata, rd_val;
    logic o_irq, o_voltage_mode, o_open_coil_a_flag, o_open_coil_b_flag;
    wire logic [1:0] open_flags = {o_open_coil_b_flag, o_open_coil_a_flag};
    logic [7:0] o_amplitude, target = 0, ofs, grad, r1;
    logic pwm_p, reach_a, reach_b, cur_low;
    int failures = 0, compares = 0, step_per = 0, scnt = 0, p, r;
    logic [7:0] c_ofs [3] = '{8'hFA, 8'h00, 8'hFF};
    logic [7:0] c_grad [3] = '{8'h0A, 8'hFF, 8'h00};
    int c_per [3] = '{256, 255, 40};

    vpas_top vpas_top_i (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr,
        .i_rd, .i_step, .i_fullstep, .i_pwm_period(pwm_p),
        .i_coil_a_reached(reach_a), .i_coil_b_reached(reach_b),
        .i_current_low(cur_low), .o_rdata, .o_irq, .o_amplitude,
        .o_voltage_mode, .o_open_coil_a_flag, .o_open_coil_b_flag);
    vpas_coil_model #(.PERIOD(32)) vpas_coil_model_i (.i_clk, .i_reset,
        .i_amplitude(o_amplitude), .i_target(target), .i_open_a(open_a),
        .i_open_b(open_b), .o_pwm_period(pwm_p),
        .o_coil_a_reached(reach_a), .o_coil_b_reached(reach_b),
        .o_current_low(cur_low));

    initial forever #5 i_clk = ~i_clk;

    always @(posedge i_clk) begin
        if (step_per != 0 && scnt + 1 >= step_per) begin
            i_step <= 1'b1;
            scnt <= 0;
        end else begin
            i_step <= 1'b0;
            scnt <= scnt + 1;
        end
    end

    // =========================================================
    // Bus, checking and expectation helpers
    task automatic chk(input logic [31:0] seen, exp, input string msg);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %0t %s: saw %h want %h", $time, msg, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 rd_val = o_rdata;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic fstep(input int n);
        repeat (n) begin
            @(posedge i_clk);
            i_fullstep <= 1'b1;
            @(posedge i_clk);
            i_fullstep <= 1'b0;
            cyc(2);
        end
    endtask

    function automatic logic [7:0] ff_total(input logic [7:0] o, g,
                                            input int per);
        int t;
        t = o + (int'(g) * 256) / per;
        return (t > 255) ? 8'hFF : 8'(t);
    endfunction

    function automatic logic [7:0] peak(input logic [7:0] t);
        return 8'((int'(t) * 248) >> 8);
    endfunction

    function automatic int reg_goal(input logic [7:0] t);
        for (int k = 0; k < 256; k++)
            if (peak(8'(k)) >= t) return k;
        return 255;
    endfunction

    task automatic finish_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // The longest path needs about 25000 cycles, so this leaves margin.
    initial begin
        repeat (80000) @(posedge i_clk);
        failures++;
        finish_test;
    end

    // =========================================================
    // Main sequence
    initial begin
        void'($urandom(27030));
        repeat (6) @(posedge i_clk);
        i_reset <= 1'b0;
        #1;
        chk({o_amplitude, o_voltage_mode, o_irq}, 0, "at reset");
        for (int a = 0; a < 16; a++) begin
            rd(4'(a));
            chk(rd_val, (a == 3) ? 32'h000F_FFFF : 0, "reset rd");
        end
        wr(4'h7, 32'hFFFF_FFFF);
        wr(ADDR_THRESH, 32'hFFFF_FFFF);
        rd(ADDR_THRESH);
        chk(rd_val, 32'h000F_FFFF, "threshold width");
        rd(ADDR_CTRL);
        chk(rd_val, 0, "unmapped write");
        // Regulation is started with the motor stopped.
        ofs = 8'($urandom_range(20, 60));
        grad = 8'($urandom_range(1, 255));
        target = 8'($urandom_range(80, 200));
        wr(ADDR_THRESH, 0);
        wr(ADDR_FF, {16'h0000, grad, ofs});
        rd(ADDR_FF);
        chk(rd_val, {16'h0000, grad, ofs}, "offset and gradient");
        wr(ADDR_CTRL, 32'h0000_0003);
        rd(ADDR_AMP);
        chk(rd_val[31:24], grad, "tuned gradient");
        cyc(32 * 240);
        rd(ADDR_AMP);
        r = reg_goal(target);
        chk(int'(rd_val[15:8]) + 2 >= r && rd_val[15:8] <= r + 1, 1,
            "regulator settle");
        chk(rd_val[7:0], rd_val[15:8], "total follows regulator");
        wr(ADDR_THRESH, 32'h0000_0100);
        step_per = 100;
        cyc(400);
        chk(o_voltage_mode, 0, "fast enough for current mode");
        rd(ADDR_AMP);
        r1 = rd_val[15:8];
        target = target + 8'h20;
        cyc(32 * 40);
        rd(ADDR_AMP);
        chk(rd_val[15:8], r1, "regulator held");
        wr(ADDR_THRESH, 0);
        rd(ADDR_AMP);
        chk(int'(rd_val[15:8]) + 1 >= r1 && rd_val[15:8] <= int'(r1) + 1,
            1, "regulator resumes");
        chk(o_voltage_mode, 1, "zero threshold");
        // =====================================================
        // Feed-forward: corners first, then random settings
        wr(ADDR_CTRL, 32'h0000_0001);
        for (int k = 0; k < 12; k++) begin
            p = (k < 3) ? c_per[k] : $urandom_range(40, 400);
            ofs = (k < 3) ? c_ofs[k] : 8'($urandom);
            grad = (k < 3) ? c_grad[k] : 8'($urandom);
            target = 8'($urandom);
            wr(ADDR_FF, {16'h0000, grad, ofs});
            step_per = p;
            cyc(3 * p + 80);
            rd(ADDR_INTERVAL);
            chk(rd_val, p, "step interval");
            rd(ADDR_AMP);
            chk(rd_val[7:0], ff_total(ofs, grad, p), "ff total");
            chk(o_amplitude, peak(ff_total(ofs, grad, p)), "peak");
        end
        target = 0;
        rd(ADDR_STATUS);
        chk(rd_val[ST_SAT], 1, "saturation event");
        chk(rd_val[ST_MODE], 1, "mode event");
        wr(ADDR_MASK, 32'h0000_0004);
        cyc(2);
        chk(o_irq, 1, "unmasked saturation");
        step_per = 0;
        wr(ADDR_STATUS, 32'h0000_000F);
        cyc(2);
        chk(o_irq, 0, "status cleared");
        step_per = 100;
        cyc(400);
        for (int d = 0; d < 2; d++) begin
            wr(ADDR_THRESH, 100 + d);
            cyc(3);
            chk(o_voltage_mode, d == 0, "threshold boundary");
        end
        wr(ADDR_THRESH, 0);
        // =====================================================
        // Open coils, one after the other
        for (int c = 0; c < 2; c++) begin
            @(posedge i_clk);
            {open_b, open_a} <= 2'(1 << c);
            cyc(4);
            fstep(3);
            chk(open_flags, 0, "3 steps");
            fstep(1);
            chk(open_flags, 1 << c, "open");
            wr(ADDR_STATUS, 32'(1 << c));
            rd(ADDR_STATUS);
            chk(rd_val[c], 1, "set beats clear");
        end
        rd(ADDR_STATUS);
        chk(rd_val[1:0], 2'b11, "open events");
        wr(ADDR_MASK, 32'h0000_0003);
        cyc(2);
        chk(o_irq, 1, "open interrupt");
        @(posedge i_clk);
        {open_b, open_a} <= 2'b00;
        cyc(6);
        chk(open_flags, 0, "reconnected");
        wr(ADDR_STATUS, 32'h0000_0003);
        cyc(2);
        chk(o_irq, 0, "open cleared");
        finish_test;
    end
endmodule
`default_nettype wire
